//--- core/compact_alu_hireg_decoder.sv
// Decoder and executor for the immediate, two-register and high-register compressed groups.
//
// Contract
// - Immediate group: byte in bits 7-0, destination 10-8, function 12-11.
// - Immediate move writes the byte to destination and sets flags.
// - Immediate compare sets flags from destination minus byte, no write.
// - Immediate add stores destination plus byte and sets flags.
// - Immediate subtract stores destination minus byte and sets flags.
// - Immediate and two-register groups always update condition flags.
// - Two-register group: destination bits 2-0, source 5-3, function above.
// - Test, compare and compare-negated set flags only.
// - Negate stores zero minus source and sets flags.
// - Multiply stores source times destination and sets flags.
// - High group: destination 2-0, source 5-3, flags bits 7 and 6, function 9-8.
// - A set bank flag maps the index into registers 8 to 15.
// - High add stores destination plus source, flags unchanged.
// - Only high compare touches the flags.
// - High move copies source into destination, flags unchanged.
// - Branch-exchange jumps to source; bit 0 picks the new state.
// - Each instruction takes as many cycles as its full-width equivalent.
`timescale 1ns/1ps
`default_nettype none
module compact_alu_hireg_decoder
  import alu_decode_pkg::*;
(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        reset,
  // Instruction hand-over from fetch.
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic [31:0] instr_addr,
  output var  logic        instr_ready,
  // Completion and register write-back.
  output var  logic        done,
  output var  logic        wb_valid,
  output var  logic [3:0]  wb_index,
  output var  logic [31:0] wb_data,
  output var  logic        unknown_instr,
  // Status and control flow.
  output var  logic [3:0]  status_flags_word,
  output var  logic        compressed_state,
  output var  logic        branch_valid,
  output var  logic [31:0] branch_target
);

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WAIT} state_type;

  state_type   state_r, state_nxt;
  logic [15:0] instr_r, instr_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [2:0]  count_r, count_nxt;
  logic        ready_r, ready_nxt, done_r, done_nxt, unknown_r, unknown_nxt;
  logic        wb_valid_r, wb_valid_nxt, branch_valid_r, branch_valid_nxt;
  logic [3:0]  wb_index_r, wb_index_nxt, flags_r, flags_nxt;
  logic [31:0] wb_data_r, wb_data_nxt, branch_target_r, branch_target_nxt;
  logic        compressed_r, compressed_nxt;

  // Execution results of the instruction held in instr_r.
  logic [31:0] rf_a, rf_b, op_a, op_b, pc_read, res;
  logic [3:0]  ex_flags;
  logic        ex_write, ex_branch, ex_state, ex_unknown;
  logic [31:0] ex_target;
  logic [2:0]  ex_cycles;
  logic        is_imm, is_alu, is_hi, in_exec;
  logic [3:0]  dst_idx, src_idx;
  logic [3:0]  alu_fn;
  logic [1:0]  imm_fn, hi_fn;

  // Destination index of any of the three groups.
  function automatic logic [3:0] dest_index(input logic [15:0] w);
    if (w[15:13] == IMM_GROUP_TOP) begin
      dest_index = {1'b0, w[IMM_DEST_LSB +: 3]};
    end else if (w[15:10] == HI_GROUP_TOP) begin
      dest_index = {w[FIRST_BANK_BIT], w[LO_DEST_LSB +: 3]};
    end else begin
      dest_index = {1'b0, w[LO_DEST_LSB +: 3]};
    end
  endfunction

  // Source index; only the high group can reach the upper bank.
  function automatic logic [3:0] source_index(input logic [15:0] w);
    if (w[15:10] == HI_GROUP_TOP) begin
      source_index = {w[SECOND_BANK_BIT], w[LO_SRC_LSB +: 3]};
    end else begin
      source_index = {1'b0, w[LO_SRC_LSB +: 3]};
    end
  endfunction

  // Adder returning carry, overflow and sum; subtraction passes the inverted operand.
  function automatic logic [33:0] add_calc(input logic [31:0] a, input logic [31:0] b, input logic cin);
    logic [32:0] s;
    s = {1'b0, a} + {1'b0, b} + {32'h0, cin};
    add_calc = {s[32], (a[31] == b[31]) && (s[31] != a[31]), s[31:0]};
  endfunction

  // Register-amount shifter returning carry out and result; amount zero keeps both.
  function automatic logic [32:0] shift_calc(input logic [3:0] fn, input logic [31:0] a,
                                             input logic [7:0] amt, input logic cin);
    logic [32:0] t;
    logic [63:0] r;
    t = {cin, a};
    r = {a, a} >> amt[4:0];
    if (amt != 8'h0) begin
      case (fn)
        ALU_LSL: begin
          if (amt < 8'h20) t = {1'b0, a} << amt;
          else if (amt == 8'h20) t = {a[0], 32'h0};
          else t = 33'h0;
        end
        ALU_LSR: begin
          if (amt < 8'h20) begin
            t = {a, 1'b0} >> amt;
            t = {t[0], t[32:1]};
          end else if (amt == 8'h20) t = {a[31], 32'h0};
          else t = 33'h0;
        end
        ALU_ASR: begin
          if (amt < 8'h20) begin
            t = 33'($signed({a, 1'b0}) >>> amt);
            t = {t[0], t[32:1]};
          end else t = {33{a[31]}};
        end
        default: begin
          if (amt[4:0] == 5'h0) t = {a[31], a};
          else t = {r[31], r[31:0]};
        end
      endcase
    end
    shift_calc = t;
  endfunction

  // Multiplier early termination: cycles grow with the significant bytes of the source.
  function automatic logic [2:0] mul_cycles(input logic [31:0] m);
    if (m[31:8] == 24'h0 || m[31:8] == 24'hFFFFFF) mul_cycles = CYC_MUL_BASE + 3'h1;
    else if (m[31:16] == 16'h0 || m[31:16] == 16'hFFFF) mul_cycles = CYC_MUL_BASE + 3'h2;
    else if (m[31:24] == 8'h0 || m[31:24] == 8'hFF) mul_cycles = CYC_MUL_BASE + 3'h3;
    else mul_cycles = CYC_MUL_BASE + 3'h4;
  endfunction

  // Operands are read when the instruction is taken and arrive in the execute cycle.
  reg_bank bank (
    .clock       (clock),
    .reset       (reset),
    .rd_addr_a   (dest_index(instr_word)),
    .rd_addr_b   (source_index(instr_word)),
    .rd_data_a_r (rf_a),
    .rd_data_b_r (rf_b),
    .wr_en       (in_exec && ex_write),
    .wr_addr     (dst_idx),
    .wr_data     (res)
  );

  // Decode of the held instruction; the program counter reads as address plus four, bit 0 clear.
  always_comb begin
    is_imm  = instr_r[15:13] == IMM_GROUP_TOP;
    is_alu  = instr_r[15:10] == ALU_GROUP_TOP;
    is_hi   = instr_r[15:10] == HI_GROUP_TOP;
    in_exec = state_r == ST_EXEC;
    dst_idx = dest_index(instr_r);
    src_idx = source_index(instr_r);
    imm_fn  = instr_r[IMM_FN_LSB +: 2];
    alu_fn  = instr_r[ALU_FN_LSB +: 4];
    hi_fn   = instr_r[HI_FN_LSB +: 2];
    pc_read = (addr_r + PC_READ_OFFSET) & ~32'h1;
    op_a    = (dst_idx == PC_INDEX) ? pc_read : rf_a;
    op_b    = (src_idx == PC_INDEX) ? pc_read : rf_b;
  end

  // Execute: result, flags, write and cycle count of the held instruction.
  always_comb begin
    logic [33:0] s;
    logic [32:0] sh;
    s = add_calc(op_a, ~op_b, 1'b1);
    sh = shift_calc(alu_fn, op_a, op_b[7:0], flags_r[FLAG_C]);
    res = op_a;
    ex_flags = flags_r;
    ex_write = 1'b0;
    ex_branch = 1'b0;
    ex_target = WORD_RESET;
    ex_state = compressed_r;
    ex_cycles = CYC_DATA;
    ex_unknown = 1'b0;
    if (is_imm) begin
      // Immediate group: the byte is zero-extended to a full word.
      ex_write = imm_fn != IMM_COMPARE;
      case (imm_fn)
        IMM_MOVE: res = {24'h0, instr_r[IMM_BYTE_LSB +: 8]};
        IMM_ADD: s = add_calc(op_a, {24'h0, instr_r[IMM_BYTE_LSB +: 8]}, 1'b0);
        default: s = add_calc(op_a, ~{24'h0, instr_r[IMM_BYTE_LSB +: 8]}, 1'b1);
      endcase
      if (imm_fn != IMM_MOVE) begin
        res = s[31:0];
        ex_flags[FLAG_C] = s[33];
        ex_flags[FLAG_V] = s[32];
      end
      ex_flags[FLAG_N] = res[31];
      ex_flags[FLAG_Z] = res == 32'h0;
    end else if (is_alu) begin
      ex_write = 1'b1;
      case (alu_fn)
        ALU_AND, ALU_TST: res = op_a & op_b;
        ALU_XOR: res = op_a ^ op_b;
        ALU_ORR: res = op_a | op_b;
        ALU_BIC: res = op_a & ~op_b;
        ALU_MVN: res = ~op_b;
        ALU_LSL, ALU_LSR, ALU_ASR, ALU_ROR: begin
          // Register-specified shifts cost one internal cycle more.
          res = sh[31:0];
          ex_flags[FLAG_C] = sh[32];
          ex_cycles = CYC_REG_SHIFT;
        end
        ALU_MUL: begin
          res = 32'(op_b * op_a);
          ex_cycles = mul_cycles(op_b);
        end
        default: begin
          // Arithmetic: carry forms, negate, compare and compare-negated.
          case (alu_fn)
            ALU_ADC: s = add_calc(op_a, op_b, flags_r[FLAG_C]);
            ALU_SBC: s = add_calc(op_a, ~op_b, flags_r[FLAG_C]);
            ALU_NEG: s = add_calc(32'h0, ~op_b, 1'b1);
            ALU_CMN: s = add_calc(op_a, op_b, 1'b0);
            default: s = add_calc(op_a, ~op_b, 1'b1);
          endcase
          res = s[31:0];
          ex_flags[FLAG_C] = s[33];
          ex_flags[FLAG_V] = s[32];
        end
      endcase
      if (alu_fn == ALU_TST || alu_fn == ALU_CMP || alu_fn == ALU_CMN) begin
        ex_write = 1'b0;
      end
      ex_flags[FLAG_N] = res[31];
      ex_flags[FLAG_Z] = res == 32'h0;
    end else if (is_hi) begin
      // Both-flags-clear forms run as plain low-register forms; software avoids them.
      case (hi_fn)
        HI_ADD: begin
          res = 32'(op_a + op_b);
          ex_write = 1'b1;
        end
        HI_COMPARE: begin
          res = s[31:0];
          ex_flags = {res[31], res == 32'h0, s[33], s[32]};
        end
        HI_MOVE: begin
          res = op_b;
          ex_write = 1'b1;
        end
        default: begin
          // Branch-exchange: bit 0 of the target picks the instruction state.
          ex_branch = 1'b1;
          ex_target = {op_b[31:1], 1'b0};
          ex_state = op_b[0];
          ex_cycles = CYC_PC_WRITE;
        end
      endcase
      // A write to the program counter is a branch that keeps the current state.
      if (ex_write && dst_idx == PC_INDEX) begin
        ex_write = 1'b0;
        ex_branch = 1'b1;
        ex_target = {res[31:1], 1'b0};
        ex_cycles = CYC_PC_WRITE;
      end
    end else begin
      ex_unknown = 1'b1;
    end
  end

  // Sequencer: take, execute, then hold for the rest of the equivalent cycle count.
  always_comb begin
    state_nxt = state_r;
    instr_nxt = instr_r;
    addr_nxt = addr_r;
    count_nxt = count_r;
    ready_nxt = ready_r;
    done_nxt = 1'b0;
    unknown_nxt = 1'b0;
    wb_valid_nxt = 1'b0;
    wb_index_nxt = wb_index_r;
    wb_data_nxt = wb_data_r;
    flags_nxt = flags_r;
    compressed_nxt = compressed_r;
    branch_valid_nxt = 1'b0;
    branch_target_nxt = branch_target_r;
    case (state_r)
      ST_IDLE: begin
        if (instr_valid) begin
          instr_nxt = instr_word;
          addr_nxt = instr_addr;
          ready_nxt = 1'b0;
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        flags_nxt = ex_flags;
        compressed_nxt = ex_state;
        unknown_nxt = ex_unknown;
        wb_valid_nxt = ex_write;
        branch_valid_nxt = ex_branch;
        if (ex_write) begin
          wb_index_nxt = dst_idx;
          wb_data_nxt = res;
        end
        if (ex_branch) begin
          branch_target_nxt = ex_target;
        end
        if (ex_cycles == CYC_DATA) begin
          done_nxt = 1'b1;
          ready_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end else begin
          count_nxt = ex_cycles - CYC_DATA;
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        count_nxt = count_r - 3'h1;
        if (count_r == 3'h1) begin
          done_nxt = 1'b1;
          ready_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // State registers.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
      instr_r <= 16'h0;
      addr_r <= WORD_RESET;
      count_r <= 3'h0;
      ready_r <= 1'b1;
      done_r <= 1'b0;
      unknown_r <= 1'b0;
      wb_valid_r <= 1'b0;
      wb_index_r <= 4'h0;
      wb_data_r <= WORD_RESET;
      flags_r <= FLAGS_RESET;
      compressed_r <= COMPRESSED_RESET;
      branch_valid_r <= 1'b0;
      branch_target_r <= WORD_RESET;
    end else begin
      state_r <= state_nxt;
      instr_r <= instr_nxt;
      addr_r <= addr_nxt;
      count_r <= count_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      unknown_r <= unknown_nxt;
      wb_valid_r <= wb_valid_nxt;
      wb_index_r <= wb_index_nxt;
      wb_data_r <= wb_data_nxt;
      flags_r <= flags_nxt;
      compressed_r <= compressed_nxt;
      branch_valid_r <= branch_valid_nxt;
      branch_target_r <= branch_target_nxt;
    end
  end

  // Outputs come straight from the registers above.
  assign instr_ready = ready_r;
  assign done = done_r;
  assign unknown_instr = unknown_r;
  assign wb_valid = wb_valid_r;
  assign wb_index = wb_index_r;
  assign wb_data = wb_data_r;
  assign status_flags_word = flags_r;
  assign compressed_state = compressed_r;
  assign branch_valid = branch_valid_r;
  assign branch_target = branch_target_r;

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  imm_move_a:
    assert property (in_exec && is_imm && imm_fn == IMM_MOVE |=>
      wb_valid_r && wb_data_r == {24'h0, $past(instr_r[7:0])} && flags_r[FLAG_Z] == (wb_data_r == 32'h0))
    else $error("immediate move did not write the byte");
  imm_compare_a:
    assert property (in_exec && is_imm && imm_fn == IMM_COMPARE |=>
      !wb_valid_r && flags_r[FLAG_Z] == ($past(op_a) == {24'h0, $past(instr_r[7:0])}))
    else $error("immediate compare wrote or set wrong zero flag");
  imm_add_a:
    assert property (in_exec && is_imm && imm_fn == IMM_ADD |=>
      wb_data_r == 32'($past(op_a) + {24'h0, $past(instr_r[7:0])}))
    else $error("immediate add result wrong");
  test_nowrite_a:
    assert property (in_exec && is_alu && (alu_fn == ALU_TST || alu_fn == ALU_CMP || alu_fn == ALU_CMN) |=>
      !wb_valid_r)
    else $error("flag-only operation wrote a register");
  negate_result_a:
    assert property (in_exec && is_alu && alu_fn == ALU_NEG |=> wb_valid_r && wb_data_r == 32'(32'h0 - $past(op_b)))
    else $error("negate result wrong");
  hi_flags_keep_a:
    assert property (in_exec && is_hi && hi_fn != HI_COMPARE |=> $stable(flags_r))
    else $error("high group changed flags outside compare");
  hi_bank_map_a:
    assert property (in_exec && is_hi && hi_fn == HI_MOVE && dst_idx != PC_INDEX |=>
      wb_index_r == {$past(instr_r[7]), $past(instr_r[2:0])} && wb_data_r == $past(op_b))
    else $error("high move used wrong register");
  branch_state_a:
    assert property (in_exec && is_hi && hi_fn == HI_BRANCH |=>
      branch_valid_r && compressed_r == $past(op_b[0]) && !done_r ##1 !done_r ##1 done_r)
    else $error("branch-exchange state or timing wrong");
  data_cycles_a:
    assert property (in_exec && is_imm |=> done_r && ready_r)
    else $error("immediate instruction not single cycle");

  cover_imm_add_c: cover property (in_exec && is_imm && imm_fn == IMM_ADD);
  cover_multiply_c: cover property (in_exec && is_alu && alu_fn == ALU_MUL ##1 state_r == ST_WAIT);
  cover_branch_c: cover property (branch_valid_r && !compressed_r);
  cover_back_to_back_c: cover property (done_r && instr_valid);

endmodule
`default_nettype wire

//--- core/alu_decode_pkg.sv
// Constants, field positions and encodings shared by the compressed ALU decoder.
package alu_decode_pkg;

  // Group identification bits at the top of the instruction word.
  localparam logic [2:0] IMM_GROUP_TOP = 3'h1;
  localparam logic [5:0] ALU_GROUP_TOP = 6'h10;
  localparam logic [5:0] HI_GROUP_TOP  = 6'h11;

  // Field positions inside the 16-bit instruction.
  localparam int IMM_BYTE_LSB   = 0;
  localparam int IMM_DEST_LSB   = 8;
  localparam int IMM_FN_LSB     = 11;
  localparam int LO_DEST_LSB    = 0;
  localparam int LO_SRC_LSB     = 3;
  localparam int ALU_FN_LSB     = 6;
  localparam int SECOND_BANK_BIT = 6;
  localparam int FIRST_BANK_BIT  = 7;
  localparam int HI_FN_LSB      = 8;

  // Immediate group function selects.
  localparam logic [1:0] IMM_MOVE    = 2'h0;
  localparam logic [1:0] IMM_COMPARE = 2'h1;
  localparam logic [1:0] IMM_ADD     = 2'h2;
  localparam logic [1:0] IMM_SUB     = 2'h3;

  // Two-register group function selects.
  localparam logic [3:0] ALU_AND = 4'h0, ALU_XOR = 4'h1, ALU_LSL = 4'h2, ALU_LSR = 4'h3;
  localparam logic [3:0] ALU_ASR = 4'h4, ALU_ADC = 4'h5, ALU_SBC = 4'h6, ALU_ROR = 4'h7;
  localparam logic [3:0] ALU_TST = 4'h8, ALU_NEG = 4'h9, ALU_CMP = 4'hA, ALU_CMN = 4'hB;
  localparam logic [3:0] ALU_ORR = 4'hC, ALU_MUL = 4'hD, ALU_BIC = 4'hE, ALU_MVN = 4'hF;

  // High-register group function selects.
  localparam logic [1:0] HI_ADD    = 2'h0;
  localparam logic [1:0] HI_COMPARE = 2'h1;
  localparam logic [1:0] HI_MOVE   = 2'h2;
  localparam logic [1:0] HI_BRANCH = 2'h3;

  // Condition flag bit positions in the status word.
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_C = 1;
  localparam int FLAG_V = 0;

  // Reset values.
  localparam logic [3:0]  FLAGS_RESET      = 4'h0;
  localparam logic        COMPRESSED_RESET = 1'b1;
  localparam logic [31:0] WORD_RESET       = 32'h0;

  // Program counter handling.
  localparam logic [3:0]  PC_INDEX       = 4'hF;
  localparam logic [31:0] PC_READ_OFFSET = 32'h4;

  // Cycle counts of the equivalent full-width instructions.
  localparam logic [2:0] CYC_DATA      = 3'h1;
  localparam logic [2:0] CYC_REG_SHIFT = 3'h2;
  localparam logic [2:0] CYC_PC_WRITE  = 3'h3;
  localparam logic [2:0] CYC_MUL_BASE  = 3'h1;

endpackage

//--- core/reg_bank.sv
// Sixteen-word register file with two registered read ports and one write port.
`timescale 1ns/1ps
`default_nettype none
module reg_bank
  import alu_decode_pkg::*;
(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        reset,
  // Read ports, data valid one cycle after the address.
  input  wire logic [3:0]  rd_addr_a,
  input  wire logic [3:0]  rd_addr_b,
  output var  logic [31:0] rd_data_a_r,
  output var  logic [31:0] rd_data_b_r,
  // Write port.
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_addr,
  input  wire logic [31:0] wr_data
);

  logic [31:0] mem [16];
  logic [31:0] rd_data_a_nxt;
  logic [31:0] rd_data_b_nxt;

  // Read data are looked up now and registered, so the array maps to plain memory.
  always_comb begin
    rd_data_a_nxt = mem[rd_addr_a];
    rd_data_b_nxt = mem[rd_addr_b];
  end

  // The array itself has no reset; software must load registers before use.
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read data.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rd_data_a_r <= WORD_RESET;
      rd_data_b_r <= WORD_RESET;
    end else begin
      rd_data_a_r <= rd_data_a_nxt;
      rd_data_b_r <= rd_data_b_nxt;
    end
  end

endmodule
`default_nettype wire

//--- dv/compact_alu_hireg_decoder_tb.sv
// Self-checking bench for the compressed ALU and high-register decoder.
`timescale 1ns/1ps
`default_nettype none
module compact_alu_hireg_decoder_tb;
  import alu_decode_pkg::*;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0;
  logic [31:0] instr_addr = 32'h0;
  logic [31:0] wb_data, branch_target, res, tgt, r;
  logic [31:0] seed = 32'h3C47ECE3;
  logic [31:0] rf [16];
  logic [3:0]  wb_index, status_flags_word;
  // Model flags start at their reset value, as the design's do.
  logic [3:0]  fl = 4'h0;
  logic        instr_ready, done, wb_valid, unknown_instr, compressed_state, branch_valid;
  logic        wr, br, un;
  logic        st = 1'b1;
  logic [15:0] w;
  int          n_errors = 0;
  int          n_checks = 0;
  int          cyc;

  compact_alu_hireg_decoder DUT (.clock, .reset, .instr_valid, .instr_word, .instr_addr, .instr_ready,
    .done, .wb_valid, .wb_index, .wb_data, .unknown_instr, .status_flags_word, .compressed_state,
    .branch_valid, .branch_target);

  // Free-running core clock at 125 MHz.
  always #4 clock = ~clock;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    // An unknown result is a mismatch even when the model is unknown as well.
    if (got !== exp || $isunknown(got)) begin
      n_errors++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask

  // Carry out is the inverse of borrow when b arrives inverted with a carry in of one.
  task automatic add3(input logic [31:0] a, input logic [31:0] b, input logic ci);
    logic [32:0] s;
    s = {1'b0, a} + {1'b0, b} + ci;
    res = s[31:0];
    fl[1] = s[32];
    fl[0] = (a[31] == b[31]) && (res[31] != a[31]);
  endtask

  // Reference model: updates the expected register file, flags, branch and cycle count.
  task automatic model(input logic [15:0] w);
    logic [31:0] a, b, pcv;
    logic [7:0]  m;
    logic [3:0]  d, s;
    logic        hi, nz;
    wr = 1'b1;
    br = 1'b0;
    cyc = 1;
    nz = 1'b1;
    hi = w[15:10] == 6'h11;
    un = w[15:13] != IMM_GROUP_TOP && w[15:10] != ALU_GROUP_TOP && w[15:10] != HI_GROUP_TOP;
    pcv = (instr_addr + 32'h4) & 32'hFFFFFFFE;
    d = {1'b0, w[10:8]};
    a = rf[d];
    b = {24'h0, w[7:0]};
    if (un) begin
      // Words outside the three groups change nothing and take one cycle.
      wr = 1'b0;
      nz = 1'b0;
    end else if (w[15:13] == IMM_GROUP_TOP) begin
      case (w[12:11])
        IMM_MOVE:    res = b;
        IMM_COMPARE: begin add3(a, ~b, 1'b1); wr = 1'b0; end
        IMM_ADD:     add3(a, b, 1'b0);
        default:     add3(a, ~b, 1'b1);
      endcase
    end else begin
      d = {hi & w[7], w[2:0]};
      s = {hi & w[6], w[5:3]};
      a = d == 4'hF ? pcv : rf[d];
      b = s == 4'hF ? pcv : rf[s];
      m = b[7:0];
      if (!hi) case (w[9:6])
        ALU_AND, ALU_TST: begin res = a & b; wr = w[9:6] != ALU_TST; end
        ALU_XOR: res = a ^ b;
        ALU_ORR: res = a | b;
        ALU_BIC: res = a & ~b;
        ALU_MVN: res = ~b;
        ALU_LSL: begin cyc = 2; res = a << m; if (m > 0) fl[1] = m > 32 ? 1'b0 : m == 32 ? a[0] : a[32-m]; end
        ALU_LSR: begin cyc = 2; res = a >> m; if (m > 0) fl[1] = m > 32 ? 1'b0 : a[m-1]; end
        ALU_ASR: begin
          // Kept out of a conditional operator, where the shift would turn logical.
          cyc = 2;
          if (m > 31) res = {32{a[31]}};
          else res = $signed(a) >>> m;
          if (m > 0) fl[1] = m > 31 ? a[31] : a[m-1];
        end
        ALU_ROR: begin
          cyc = 2;
          res = (a >> m[4:0]) | (a << (6'd32 - m[4:0]));
          if (m > 0) fl[1] = m[4:0] == 0 ? a[31] : a[m[4:0]-1];
        end
        ALU_ADC: add3(a, b, fl[1]);
        ALU_SBC: add3(a, ~b, fl[1]);
        ALU_NEG: add3(32'h0, ~b, 1'b1);
        ALU_CMP: begin add3(a, ~b, 1'b1); wr = 1'b0; end
        ALU_CMN: begin add3(a, b, 1'b0); wr = 1'b0; end
        default: begin
          res = a * b;
          if (b[31:8] == 0 || &b[31:8]) cyc = 2;
          else if (b[31:16] == 0 || &b[31:16]) cyc = 3;
          else if (b[31:24] == 0 || &b[31:24]) cyc = 4;
          else cyc = 5;
        end
      endcase else begin
        nz = 1'b0;
        case (w[9:8])
          HI_ADD:     res = a + b;
          HI_COMPARE: begin add3(a, ~b, 1'b1); nz = 1'b1; wr = 1'b0; end
          HI_MOVE:    res = b;
          default:    begin wr = 1'b0; br = 1'b1; tgt = b & 32'hFFFFFFFE; st = b[0]; cyc = 3; end
        endcase
        if (wr && d == 4'hF) begin wr = 1'b0; br = 1'b1; tgt = res & 32'hFFFFFFFE; cyc = 3; end
      end
    end
    if (nz) begin fl[3] = res[31]; fl[2] = res == 0; end
    if (wr) rf[d] = res;
  endtask

  // One instruction: offer it, let it be taken, check results at the first edge and done at the last.
  task automatic run(input logic [15:0] w);
    int n;
    @(posedge clock);
    instr_valid <= 1'b1;
    instr_word <= w;
    instr_addr <= xs() & 32'hFFFFFFFE;
    @(posedge clock);
    instr_valid <= 1'b0;
    model(w);
    // Results land at the edge after the take edge, so look only after it.
    @(posedge clock);
    for (n = 1; n <= 8; n++) begin
      @(negedge clock);
      if (n == 1) begin
        chk(status_flags_word, fl);
        chk(wb_valid, wr);
        if (wr) chk({wb_index, wb_data}, {d_of(w), res});
        chk(branch_valid, br);
        if (br) chk(branch_target, tgt);
        chk(compressed_state, st);
        chk(unknown_instr, un);
        chk(instr_ready, cyc == 1);
      end
      if (done === 1'b1) break;
    end
    chk(n, cyc);
  endtask

  function automatic logic [3:0] d_of(input logic [15:0] w);
    return w[15:13] == IMM_GROUP_TOP ? {1'b0, w[10:8]} : {w[15:10] == 6'h11 & w[7], w[2:0]};
  endfunction

  task automatic wrap_up;
    if (n_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Main sequence: load registers, sweep every two-register select, then a random instruction mix.
  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) run({5'h04, 3'(i), 8'(xs())});
    for (int i = 8; i < 15; i++) run({6'h11, 2'h2, 2'h2, 3'(xs()), 3'(i)});
    run(16'h31FF);
    run(16'hE000);
    for (int f = 0; f < 16; f++) run({6'h10, 4'(f), 6'(xs())});
    for (int i = 0; i < 400; i++) begin
      r = xs();
      w = {6'h11, r[9:0]};
      if (w[9:8] == HI_BRANCH) w[7] = 1'b0;
      else if (w[7:6] == 2'h0) w[6] = 1'b1;
      case (r[31:30])
        2'h0: run({3'h1, r[12:0]});
        2'h1: run({6'h10, r[13:4]});
        2'h2: run(w);
        default: run({5'h04, r[10:8], 3'h0, r[4:0]});
      endcase
    end
    wrap_up;
  end

  // Watchdog well beyond the expected run length.
  initial begin
    #(8 * 20000);
    n_errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
